// ### core/reset_strap_address_config.sv
// strap capture at reset release and address pin driver for the secondary memory interface
`timescale 1ns/10ps
module reset_strap_address_config #(
	parameter int SETTLE_CYCLES = strap_cfg_pkg::SETTLE_CYC
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// address from the secondary memory interface
	input wire logic [strap_cfg_pkg::ADDR_W-1:0] mem_addr_i,
	input wire logic mem_addr_oe_i,
	// secondary_ext_address pins, bit 0 here is address bit 1
	input wire logic [strap_cfg_pkg::ADDR_W-1:0] secondary_ext_address_i,
	output logic [strap_cfg_pkg::ADDR_W-1:0] secondary_ext_address_o,
	output logic [strap_cfg_pkg::ADDR_W-1:0] secondary_ext_address_oe_o,
	// latched configuration
	output logic little_endian_o,
	output logic [1:0] boot_mode_o,
	output logic [1:0] primary_clk_source_sel_o,
	output logic [1:0] secondary_clk_source_sel_o,
	output logic pci_eeprom_autoinit_o,
	output logic cell_interface_enable_o,
	output logic serial_port_one_enable_o,
	output logic strap_reserved_o,
	output logic config_valid_o,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	typedef enum logic [1:0] {ST_SETTLE, ST_CAPTURE, ST_RUN} cap_state_t;

	localparam logic [strap_cfg_pkg::SETTLE_W-1:0] SETTLE_LAST =
		strap_cfg_pkg::SETTLE_W'(SETTLE_CYCLES - 1);

	// synchronised pin levels
	logic [strap_cfg_pkg::ADDR_W-1:0] pins_sync;

	// pins come straight from the board, so they pass two flops first
	pin_sync #(
		.WIDTH(strap_cfg_pkg::ADDR_W)
	) u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.async_i(secondary_ext_address_i),
		.sync_o(pins_sync)
	);

	logic dec_little;
	logic [1:0] dec_boot;
	logic [1:0] dec_pri_clk;
	logic [1:0] dec_sec_clk;
	logic dec_autoinit;
	logic dec_cell;
	logic dec_reserved;

	strap_decode u_strap_decode (
		.strap_i(pins_sync),
		.little_endian_o(dec_little),
		.boot_mode_o(dec_boot),
		.primary_clk_source_sel_o(dec_pri_clk),
		.secondary_clk_source_sel_o(dec_sec_clk),
		.pci_eeprom_autoinit_o(dec_autoinit),
		.cell_interface_enable_o(dec_cell),
		.reserved_code_o(dec_reserved)
	);

	// capture sequencer
	cap_state_t state;
	cap_state_t next_state;
	logic [strap_cfg_pkg::SETTLE_W-1:0] settle_cnt;
	logic [strap_cfg_pkg::SETTLE_W-1:0] next_settle_cnt;

	always_comb begin
		next_state = state;
		next_settle_cnt = settle_cnt;
		case (state)
			ST_SETTLE: begin
				// synchroniser was reset to zero; wait until it holds real pin levels
				if (settle_cnt == SETTLE_LAST) begin
					next_state = ST_CAPTURE;
				end else begin
					next_settle_cnt = settle_cnt + 1'b1;
				end
			end
			ST_CAPTURE: begin
				next_state = ST_RUN;
			end
			ST_RUN: begin
				// held until the next reset
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= ST_SETTLE;
			settle_cnt <= '0;
		end else begin
			state <= next_state;
			settle_cnt <= next_settle_cnt;
		end
	end

	// latched configuration
	logic next_little;
	logic [1:0] next_boot;
	logic [1:0] next_pri_clk;
	logic [1:0] next_sec_clk;
	logic next_autoinit;
	logic next_cell;
	logic next_reserved;
	logic next_valid;
	logic [strap_cfg_pkg::ADDR_W-1:0] raw_strap;
	logic [strap_cfg_pkg::ADDR_W-1:0] next_raw_strap;

	always_comb begin
		next_little = little_endian_o;
		next_boot = boot_mode_o;
		next_pri_clk = primary_clk_source_sel_o;
		next_sec_clk = secondary_clk_source_sel_o;
		next_autoinit = pci_eeprom_autoinit_o;
		next_cell = cell_interface_enable_o;
		next_reserved = strap_reserved_o;
		next_valid = config_valid_o;
		next_raw_strap = raw_strap;
		if (state == ST_CAPTURE) begin
			// pins are still inputs here: the drivers stay off until ST_RUN
			next_little = dec_little;
			next_boot = dec_boot;
			next_pri_clk = dec_pri_clk;
			next_sec_clk = dec_sec_clk;
			next_autoinit = dec_autoinit;
			next_cell = dec_cell;
			next_reserved = dec_reserved;
			next_valid = 1'b1;
			next_raw_strap = pins_sync;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			little_endian_o <= strap_cfg_pkg::RST_LITTLE_ENDIAN;
			boot_mode_o <= strap_cfg_pkg::RST_BOOT;
			primary_clk_source_sel_o <= strap_cfg_pkg::RST_PRI_CLK;
			secondary_clk_source_sel_o <= strap_cfg_pkg::RST_SEC_CLK;
			pci_eeprom_autoinit_o <= strap_cfg_pkg::RST_AUTOINIT;
			cell_interface_enable_o <= strap_cfg_pkg::RST_CELL_EN;
			serial_port_one_enable_o <= !strap_cfg_pkg::RST_CELL_EN;
			strap_reserved_o <= 1'b0;
			config_valid_o <= 1'b0;
			raw_strap <= '0;
		end else begin
			little_endian_o <= next_little;
			boot_mode_o <= next_boot;
			primary_clk_source_sel_o <= next_pri_clk;
			secondary_clk_source_sel_o <= next_sec_clk;
			pci_eeprom_autoinit_o <= next_autoinit;
			cell_interface_enable_o <= next_cell;
			serial_port_one_enable_o <= !next_cell;
			strap_reserved_o <= next_reserved;
			config_valid_o <= next_valid;
			raw_strap <= next_raw_strap;
		end
	end

	// address pin drivers
	logic drive_en;
	logic [strap_cfg_pkg::ADDR_W-1:0] next_addr;
	logic [strap_cfg_pkg::ADDR_W-1:0] next_addr_oe;

	always_comb begin
		next_addr = secondary_ext_address_o;
		next_addr_oe = '0;
		if (state == ST_RUN) begin
			// drivers only after capture, so the straps never fight our own output
			next_addr = mem_addr_i;
			if (drive_en && mem_addr_oe_i) begin
				next_addr_oe = '1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			secondary_ext_address_o <= '0;
			secondary_ext_address_oe_o <= '0;
		end else begin
			secondary_ext_address_o <= next_addr;
			secondary_ext_address_oe_o <= next_addr_oe;
		end
	end

	// wishbone register slave, one wait state: ack one edge after the strobe
	logic req;
	logic next_drive_en;
	logic next_ack;
	logic [31:0] next_dat;
	logic [31:0] cfg_word;

	always_comb begin
		req = wb_cyc_i && wb_stb_i && !wb_ack_o;
		cfg_word = '0;
		cfg_word[strap_cfg_pkg::CFG_ENDIAN_POS] = little_endian_o;
		cfg_word[strap_cfg_pkg::CFG_BOOT_LSB+:2] = boot_mode_o;
		cfg_word[strap_cfg_pkg::CFG_PRI_CLK_LSB+:2] = primary_clk_source_sel_o;
		cfg_word[strap_cfg_pkg::CFG_SEC_CLK_LSB+:2] = secondary_clk_source_sel_o;
		cfg_word[strap_cfg_pkg::CFG_AUTOINIT_POS] = pci_eeprom_autoinit_o;
		cfg_word[strap_cfg_pkg::CFG_CELL_EN_POS] = cell_interface_enable_o;
		cfg_word[strap_cfg_pkg::CFG_RESERVED_POS] = strap_reserved_o;
		cfg_word[strap_cfg_pkg::CFG_VALID_POS] = config_valid_o;
		next_ack = req;
		next_drive_en = drive_en;
		next_dat = wb_dat_o;
		if (req) begin
			next_dat = '0;
			case (wb_adr_i)
				strap_cfg_pkg::REG_CTRL: begin
					next_dat[strap_cfg_pkg::CTRL_DRIVE_POS] = drive_en;
					if (wb_we_i && wb_sel_i[0]) begin
						next_drive_en = wb_dat_i[strap_cfg_pkg::CTRL_DRIVE_POS];
					end
				end
				strap_cfg_pkg::REG_CONFIG: begin
					next_dat = cfg_word;
				end
				strap_cfg_pkg::REG_RAW: begin
					// pin k of the vector is address bit k+1
					next_dat[strap_cfg_pkg::ADDR_MSB:strap_cfg_pkg::ADDR_LSB] = raw_strap;
				end
				default: begin
					// unmapped: acknowledged, reads zero, writes dropped
					next_dat = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			drive_en <= strap_cfg_pkg::RST_DRIVE_EN;
		end else begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			drive_en <= next_drive_en;
		end
	end
endmodule : reset_strap_address_config

// ### core/strap_cfg_pkg.sv
// constants for the reset-time strap capture on the secondary address pins
// Behaviour
// - drive half-word address pins, tristate capable
// - during reset pins are inputs, straps sampled; the code captures them SETTLE_CYC+1 clock edges after reset release
// - bit 20 selects byte order, little default
// - bits 19:18 select boot source, ROM default
// - bits 17:16 select primary memory clock
// - bits 15:14 select secondary memory clock
// - bit 13 high enables PCI EEPROM autoinit
// - bit 11 picks cell interface or serial port one
package strap_cfg_pkg;
	localparam int ADDR_LSB = 1;
	localparam int ADDR_MSB = 20;
	localparam int ADDR_W = ADDR_MSB - ADDR_LSB + 1;

	// strap field positions on the address pins
	localparam int ENDIAN_POS = 20;
	localparam int BOOT_LSB = 18;
	localparam int PRI_CLK_LSB = 16;
	localparam int SEC_CLK_LSB = 14;
	localparam int AUTOINIT_POS = 13;
	localparam int CELL_EN_POS = 11;

	// field encodings
	localparam logic [1:0] BOOT_NONE = 2'h0;
	localparam logic [1:0] BOOT_HOST_PORT = 2'h1;
	localparam logic [1:0] BOOT_ROM8 = 2'h2;
	localparam logic [1:0] CLK_EXT_IN = 2'h0;
	localparam logic [1:0] CLK_CPU_DIV4 = 2'h1;
	localparam logic [1:0] CLK_CPU_DIV6 = 2'h2;
	localparam logic [1:0] CODE_RESERVED = 2'h3;

	// defaults held until the first capture; RST_DRIVE_EN holds until a control write with byte lane 0 enabled
	localparam logic RST_LITTLE_ENDIAN = 1'b1;
	localparam logic [1:0] RST_BOOT = BOOT_ROM8;
	localparam logic [1:0] RST_PRI_CLK = CLK_EXT_IN;
	localparam logic [1:0] RST_SEC_CLK = CLK_EXT_IN;
	localparam logic RST_AUTOINIT = 1'b0;
	localparam logic RST_CELL_EN = 1'b0;
	localparam logic RST_DRIVE_EN = 1'b1;

	// settle time after reset release before the capture
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETTLE_NS = 40;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 4;

	// register map, byte addresses on the bus
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CONFIG = 8'h04;
	localparam logic [7:0] REG_RAW = 8'h08;
	localparam int CTRL_DRIVE_POS = 0;
	localparam int CFG_ENDIAN_POS = 0;
	localparam int CFG_BOOT_LSB = 1;
	localparam int CFG_PRI_CLK_LSB = 3;
	localparam int CFG_SEC_CLK_LSB = 5;
	localparam int CFG_AUTOINIT_POS = 7;
	localparam int CFG_CELL_EN_POS = 8;
	localparam int CFG_RESERVED_POS = 9;
	localparam int CFG_VALID_POS = 10;
endpackage : strap_cfg_pkg

// ### core/pin_sync.sv
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 20
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// levels
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					stage1[g] <= 1'b0;
					stage2[g] <= 1'b0;
				end else begin
					stage1[g] <= async_i[g];
					stage2[g] <= stage1[g];
				end
			end
		end
	endgenerate

	assign sync_o = stage2;
endmodule : pin_sync

// ### core/strap_decode.sv
// decodes the sampled address pin levels into configuration fields
`timescale 1ns/10ps
module strap_decode (
	// sampled pins, index is the address bit number
	input wire logic [strap_cfg_pkg::ADDR_MSB:strap_cfg_pkg::ADDR_LSB] strap_i,
	// decoded fields
	output logic little_endian_o,
	output logic [1:0] boot_mode_o,
	output logic [1:0] primary_clk_source_sel_o,
	output logic [1:0] secondary_clk_source_sel_o,
	output logic pci_eeprom_autoinit_o,
	output logic cell_interface_enable_o,
	output logic reserved_code_o
);
	always_comb begin
		little_endian_o = strap_i[strap_cfg_pkg::ENDIAN_POS];
		boot_mode_o = strap_i[strap_cfg_pkg::BOOT_LSB+1:strap_cfg_pkg::BOOT_LSB];
		primary_clk_source_sel_o =
			strap_i[strap_cfg_pkg::PRI_CLK_LSB+1:strap_cfg_pkg::PRI_CLK_LSB];
		secondary_clk_source_sel_o =
			strap_i[strap_cfg_pkg::SEC_CLK_LSB+1:strap_cfg_pkg::SEC_CLK_LSB];
		pci_eeprom_autoinit_o = strap_i[strap_cfg_pkg::AUTOINIT_POS];
		cell_interface_enable_o = strap_i[strap_cfg_pkg::CELL_EN_POS];
		// reserved codes are passed through but flagged so software can see a bad board
		reserved_code_o = (boot_mode_o == strap_cfg_pkg::CODE_RESERVED)
			|| (primary_clk_source_sel_o == strap_cfg_pkg::CODE_RESERVED)
			|| (secondary_clk_source_sel_o == strap_cfg_pkg::CODE_RESERVED);
	end
endmodule : strap_decode

// ### dv/strap_board.sv
// board strap resistors and pin wiring on the secondary address lines
`timescale 1ns/10ps
module strap_board #(
	parameter logic [19:0] PULLS = 20'h00000
) (
	// strap pattern chosen by the bench
	input wire logic [19:0] strap_i,
	// device pin drive
	input wire logic [19:0] drive_i,
	input wire logic [19:0] drive_oe_i,
	// resolved pin levels
	output logic [19:0] pin_o
);
	// a pin the device releases settles to its resistor level, never to its last driven value
	always_comb begin
		for (int k = 0; k < 20; k++) begin
			pin_o[k] = drive_oe_i[k] ? drive_i[k] : (strap_i[k] | PULLS[k]);
		end
	end
endmodule : strap_board

// ### dv/strap_cfg_checker_asserts.sv
// concurrent checks on the strap capture and address pin driver
`timescale 1ns/10ps
module strap_cfg_checker #(
	parameter int SETTLE_CYCLES = 4
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// pins
	input wire logic [strap_cfg_pkg::ADDR_W-1:0] mem_addr_i,
	input wire logic mem_addr_oe_i,
	input wire logic [strap_cfg_pkg::ADDR_W-1:0] secondary_ext_address_i,
	input wire logic [strap_cfg_pkg::ADDR_W-1:0] secondary_ext_address_o,
	input wire logic [strap_cfg_pkg::ADDR_W-1:0] secondary_ext_address_oe_o,
	// configuration
	input wire logic little_endian_o,
	input wire logic [1:0] boot_mode_o,
	input wire logic [1:0] primary_clk_source_sel_o,
	input wire logic [1:0] secondary_clk_source_sel_o,
	input wire logic pci_eeprom_autoinit_o,
	input wire logic cell_interface_enable_o,
	input wire logic serial_port_one_enable_o,
	input wire logic config_valid_o,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o
);
	// release edge to the first sample of the captured flag
	localparam int CAPTURE_BOUND = SETTLE_CYCLES + 1;
	logic [8:0] cfg;
	assign cfg = {little_endian_o, boot_mode_o, primary_clk_source_sel_o,
		secondary_clk_source_sel_o, pci_eeprom_autoinit_o, cell_interface_enable_o};
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	a_oe_uniform: assert property (secondary_ext_address_oe_o == '0 || &secondary_ext_address_oe_o)
		else $error("output enables differ between pins");
	a_no_early_drive: assert property (!config_valid_o |-> secondary_ext_address_oe_o == '0)
		else $error("pins driven before capture");
	a_oe_release: assert property (!mem_addr_oe_i |=> secondary_ext_address_oe_o == '0)
		else $error("pins still driven after release");
	a_addr_follow: assert property (secondary_ext_address_oe_o[0] |->
		$past(mem_addr_oe_i) && secondary_ext_address_o == $past(mem_addr_i))
		else $error("pin address not the registered memory address");
	a_config_held: assert property (config_valid_o |=> config_valid_o && $stable(cfg))
		else $error("configuration changed after capture");
	a_port_choice: assert property (serial_port_one_enable_o == !cell_interface_enable_o)
		else $error("serial port and cell interface both on or off");
	a_default_cfg: assert property (!config_valid_o |-> cfg == 9'h180)
		else $error("defaults wrong before capture");
	a_capture_pins: assert property ($rose(config_valid_o) |->
		cfg == {$past(secondary_ext_address_i[19:12], 2), $past(secondary_ext_address_i[10], 2)})
		else $error("captured fields differ from pin levels");
	a_capture_time: assert property ($rose(arst_n_i) |-> ##[1:CAPTURE_BOUND] config_valid_o)
		else $error("straps not captured in time after reset");
	a_ack_pulse: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a single cycle pulse");
endmodule : strap_cfg_checker

bind reset_strap_address_config strap_cfg_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (
	.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .mem_addr_i(mem_addr_i),
	.mem_addr_oe_i(mem_addr_oe_i), .secondary_ext_address_i(secondary_ext_address_i),
	.secondary_ext_address_o(secondary_ext_address_o),
	.secondary_ext_address_oe_o(secondary_ext_address_oe_o), .little_endian_o(little_endian_o),
	.boot_mode_o(boot_mode_o), .primary_clk_source_sel_o(primary_clk_source_sel_o),
	.secondary_clk_source_sel_o(secondary_clk_source_sel_o),
	.pci_eeprom_autoinit_o(pci_eeprom_autoinit_o),
	.cell_interface_enable_o(cell_interface_enable_o),
	.serial_port_one_enable_o(serial_port_one_enable_o), .config_valid_o(config_valid_o),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// ### dv/tb_reset_strap_address_config.sv
// self-checking bench for the strap capture and address pin driver
`timescale 1ns/10ps
module tb_reset_strap_address_config;
	localparam logic [19:0] PULLS = 20'h00180;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [19:0] mem_addr_i = 20'h00000;
	logic mem_addr_oe_i = 1'b0;
	logic [19:0] strap = 20'h00000;
	logic [19:0] pin, pin_o, pin_oe;
	logic le, ai, ce, sp, rs, vd, ack;
	logic [1:0] bm, pc, sc;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] sel = 4'hf;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rd;
	int err_count = 0;
	int samples_checked = 0;

	always #5 clk_sys_i = ~clk_sys_i;

	strap_board #(.PULLS(PULLS)) i_board (.strap_i(strap), .drive_i(pin_o), .drive_oe_i(pin_oe),
		.pin_o(pin));

	reset_strap_address_config #(.SETTLE_CYCLES(4)) i_dut (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .mem_addr_i(mem_addr_i), .mem_addr_oe_i(mem_addr_oe_i),
		.secondary_ext_address_i(pin), .secondary_ext_address_o(pin_o),
		.secondary_ext_address_oe_o(pin_oe), .little_endian_o(le), .boot_mode_o(bm),
		.primary_clk_source_sel_o(pc), .secondary_clk_source_sel_o(sc),
		.pci_eeprom_autoinit_o(ai), .cell_interface_enable_o(ce), .serial_port_one_enable_o(sp),
		.strap_reserved_o(rs), .config_valid_o(vd), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
		.wb_ack_o(ack));

	task automatic give_verdict();
		if (err_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			$display("unexpected %s expected %h seen %h", nm, ex, got);
			err_count++;
		end
	endtask : chk

	// ack is read before the edge's own updates land, so the last cycle's answer is seen
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge clk_sys_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk_sys_i);
		if (ack !== 1'b1) begin
			err_count++;
			give_verdict();
		end
		r = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic t_capture(input logic [8:0] f);
		logic [31:0] r;
		int n;
		@(posedge clk_sys_i);
		arst_n_i <= 1'b0;
		strap <= {f[8:1], 1'b0, f[0], 10'h000};
		repeat (4) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		for (n = 0; n < 20 && vd !== 1'b1; n++) @(posedge clk_sys_i);
		if (vd !== 1'b1) begin
			err_count++;
			give_verdict();
		end
		chk("outputs", {22'h0, f, ~f[0]}, {22'h0, le, bm, pc, sc, ai, ce, sp});
		chk("reserved", 32'h0, {31'h0, rs});
		wb(1'b0, 8'h04, 32'h0, r);
		chk("config", {21'h0, 2'h2, f[0], f[1], f[3:2], f[5:4], f[7:6], f[8]}, r);
		wb(1'b0, 8'h08, 32'h0, r);
		chk("raw", {11'h0, strap | PULLS, 1'b0}, r);
	endtask : t_capture

	task automatic t_drive(input logic [8:0] f);
		logic [31:0] r;
		@(posedge clk_sys_i);
		mem_addr_i <= 20'ha5a5a;
		mem_addr_oe_i <= 1'b1;
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk("pins", 32'h000a5a5a, {12'h0, pin_o});
		chk("enables", 32'h000fffff, {12'h0, pin_oe});
		// a write with byte lane 0 masked must leave the drivers on
		@(posedge clk_sys_i);
		sel <= 4'h0;
		wb(1'b1, 8'h00, 32'h0, r);
		@(negedge clk_sys_i);
		chk("masked", 32'h000fffff, {12'h0, pin_oe});
		@(posedge clk_sys_i);
		sel <= 4'hf;
		wb(1'b1, 8'h00, 32'h0, r);
		@(negedge clk_sys_i);
		chk("released", 32'h0, {12'h0, pin_oe});
		wb(1'b0, 8'h00, 32'h0, r);
		chk("ctrl", 32'h0, r);
		wb(1'b1, 8'h04, 32'hffffffff, r);
		wb(1'b0, 8'hfc, 32'h0, r);
		chk("unmapped", 32'h0, r);
		chk("held", {22'h0, f, ~f[0]}, {22'h0, le, bm, pc, sc, ai, ce, sp});
		wb(1'b1, 8'h00, 32'h1, r);
		@(negedge clk_sys_i);
		chk("restored", 32'h000fffff, {12'h0, pin_oe});
	endtask : t_drive

	initial begin
		t_capture(9'h01b);
		t_capture(9'h160);
		t_drive(9'h160);
		t_capture(9'h185);
		give_verdict();
	end
endmodule : tb_reset_strap_address_config
